// File: shared/trb_consts.vh
/*
 * Constants shared by the timer and relay function blocks: the time base, the delay range,
 * the unit codes, the input bit positions and the reset values.
 * Assumes a single 100 MHz core clock; no process or assignment lives here.
 */
`ifndef TRB_CONSTS_VH
`define TRB_CONSTS_VH

`define TRB_CLK_PERIOD_NS   10
`define TRB_BASE_TIME_US    10000
`define TRB_SEC_PER_MIN     60
`define TRB_SEC_PER_HOUR    3600

`define TRB_DELAY_W         14
`define TRB_DELAY_MIN       14'h0001
`define TRB_DELAY_MAX       14'h270F

`define TRB_UNIT_SEC        2'h0
`define TRB_UNIT_MIN        2'h1
`define TRB_UNIT_HOUR       2'h2

`define TRB_IN_W            7
`define TRB_IN_ON_TRG       0
`define TRB_IN_OFF_TRG      1
`define TRB_IN_OFF_RST      2
`define TRB_IN_TGL_TRG      3
`define TRB_IN_TGL_RST      4
`define TRB_IN_LAT_SET      5
`define TRB_IN_LAT_RST      6

`define TRB_SYNC_RESET      7'h00
`define TRB_TGL_PREV_RESET  1'b1

`endif

// File: rtl/trb_delay_timer.v
/*
 * One delay timer counting hundredths of the selected unit up to a clamped delay value.
 * Assumes the three unit ticks are one-cycle pulses from the core clock domain.
 */
`timescale 1ns/1ns
`include "trb_consts.vh"

module trb_delay_timer (
	input  wire                     core_clk,
	input  wire                     resetn,
	input  wire                     clkEn,
	input  wire                     tickSec,
	input  wire                     tickMin,
	input  wire                     tickHour,
	input  wire [1:0]               unitSel,
	input  wire [`TRB_DELAY_W-1:0]  delayVal,
	input  wire                     run,
	input  wire                     clear,
	output wire                     done
);

	reg  [`TRB_DELAY_W-1:0] count_ff;
	reg  [`TRB_DELAY_W-1:0] nxt_count;
	reg                     tick;

	always @* begin
		case (unitSel)
			`TRB_UNIT_MIN:  tick = tickMin;
			`TRB_UNIT_HOUR: tick = tickHour;
			default:        tick = tickSec;
		endcase
	end

	// The count saturates at the delay so a long run never wraps back below it.
	always @* begin
		nxt_count = count_ff;
		if (clear) begin
			nxt_count = {`TRB_DELAY_W{1'b0}};
		end else if (run && tick && !done) begin
			nxt_count = count_ff + 14'h0001; // see R17
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_ff <= {`TRB_DELAY_W{1'b0}};
		end else if (clkEn) begin
			count_ff <= nxt_count;
		end
	end

	assign done = (count_ff >= delayVal); // see R17

endmodule // trb_delay_timer

// File: rtl/trb_function_blocks.v
/*
 * Scan-evaluated on-delay timer, off-delay timer, edge toggle relay and set/clear latch,
 * with the shared time base and the parameter hand-off to the operator panel.
 * Assumes block inputs may come from terminals of another domain, scanTick and the
 * configuration inputs come from logic on core_clk.
 */
`timescale 1ns/1ns
`include "trb_consts.vh"

// Contract
// R1: On-delay timing starts on trigger rise; output goes 1 after the delay.
// R2: Trigger falling before the delay clears the count; output stays 0.
// R3: On-delay output is 0 while its trigger is 0.
// R4: Delay takes 0.01 to 99.99 with unit hours, minutes or seconds.
// R5: Off-delay output is 1 at once while its trigger is 1.
// R6: Trigger fall starts the off timer with output 1; expiry clears both.
// R7: Every further trigger fall restarts the off-delay timer from zero.
// R8: Off-delay reset clears timer and output at any time, over trigger.
// R9: Unconnected trigger, reset or enable inputs read as constant 0.
// R10: Toggle relay inverts output on each trigger rise, holds otherwise.
// R11: Toggle reset forces output 0, winning over a simultaneous rise.
// R12: Toggle output is cleared to 0 at power up and power down.
// R13: Trigger already 1 at start counts as a fall; no toggle until it rises.
// R14: Latch holds on 00, sets on set only, clears whenever reset is 1.
// R15: Linked timer parameter ports present their delay to the operator panel.
// R16: Inputs sampled and outputs updated once per scan; edges versus last scan.
// R17: Timers count hundredths of the selected unit against the delay value.
module trb_function_blocks #(
	parameter TICK_CYCLES = (`TRB_BASE_TIME_US * 1000) / `TRB_CLK_PERIOD_NS
) (
	input  wire                     core_clk,
	input  wire                     resetn,
	input  wire                     clkEn,
	input  wire                     scanTick,
	input  wire [`TRB_IN_W-1:0]     blockIn,
	input  wire [`TRB_IN_W-1:0]     blockInConn,
	input  wire [`TRB_DELAY_W-1:0]  onDelayVal,
	input  wire [1:0]               onDelayUnit,
	input  wire [`TRB_DELAY_W-1:0]  offDelayVal,
	input  wire [1:0]               offDelayUnit,
	input  wire                     onParamLink,
	input  wire                     offParamLink,
	output wire                     onDelayOut,
	output wire                     offDelayOut,
	output wire                     toggleOut,
	output wire                     latchOut,
	output wire                     onPanelValid,
	output wire [`TRB_DELAY_W-1:0]  onPanelDelay,
	output wire [1:0]               onPanelUnit,
	output wire                     offPanelValid,
	output wire [`TRB_DELAY_W-1:0]  offPanelDelay,
	output wire [1:0]               offPanelUnit
);

	function [`TRB_DELAY_W-1:0] clampDelay;
		input [`TRB_DELAY_W-1:0] raw;
		begin
			if (raw < `TRB_DELAY_MIN) begin
				clampDelay = `TRB_DELAY_MIN;
			end else if (raw > `TRB_DELAY_MAX) begin
				clampDelay = `TRB_DELAY_MAX;
			end else begin
				clampDelay = raw;
			end
		end
	endfunction

	function [1:0] clampUnit;
		input [1:0] raw;
		begin
			if (raw == `TRB_UNIT_MIN || raw == `TRB_UNIT_HOUR) begin
				clampUnit = raw;
			end else begin
				clampUnit = `TRB_UNIT_SEC;
			end
		end
	endfunction

	reg  [`TRB_IN_W-1:0]     syncA_ff;
	reg  [`TRB_IN_W-1:0]     syncB_ff;
	reg  [31:0]              baseCnt_ff;
	reg  [11:0]              minCnt_ff;
	reg  [11:0]              hourCnt_ff;
	reg                      onOut_ff;
	reg                      onTrg_ff;
	reg                      offOut_ff;
	reg                      offRun_ff;
	reg                      offTrgPrev_ff;
	reg                      tglOut_ff;
	reg                      tglPrev_ff;
	reg                      latOut_ff;
	reg                      onLink_ff;
	reg                      offLink_ff;
	reg  [`TRB_DELAY_W-1:0]  onPanDelay_ff;
	reg  [`TRB_DELAY_W-1:0]  offPanDelay_ff;
	reg  [1:0]               onPanUnit_ff;
	reg  [1:0]               offPanUnit_ff;
	reg                      nxt_offOut;
	reg                      nxt_offRun;
	reg                      offClear;

	wire [`TRB_IN_W-1:0]     inEff;
	wire                     tickSec;
	wire                     tickMin;
	wire                     tickHour;
	wire                     onDone;
	wire                     offDone;
	wire [`TRB_DELAY_W-1:0]  onDelay;
	wire [`TRB_DELAY_W-1:0]  offDelay;
	wire [1:0]               onUnit;
	wire [1:0]               offUnit;

	// Terminal levels cross into core_clk through two flops before anything looks at them.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_ff <= `TRB_SYNC_RESET;
			syncB_ff <= `TRB_SYNC_RESET;
		end else if (clkEn) begin
			syncA_ff <= blockIn;
			syncB_ff <= syncA_ff;
		end
	end

	assign inEff    = syncB_ff & blockInConn; // see R9
	assign onDelay  = clampDelay(onDelayVal); // see R4
	assign offDelay = clampDelay(offDelayVal); // see R4
	assign onUnit   = clampUnit(onDelayUnit); // see R4
	assign offUnit  = clampUnit(offDelayUnit); // see R4

	// Minute and hour hundredths are derived from the seconds tick to share one long divider.
	assign tickSec  = (baseCnt_ff == TICK_CYCLES - 1); // see R17
	assign tickMin  = tickSec && (minCnt_ff == `TRB_SEC_PER_MIN - 1);
	assign tickHour = tickSec && (hourCnt_ff == `TRB_SEC_PER_HOUR - 1);

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			baseCnt_ff <= 32'h0000_0000;
			minCnt_ff  <= 12'h000;
			hourCnt_ff <= 12'h000;
		end else if (clkEn) begin
			baseCnt_ff <= tickSec ? 32'h0000_0000 : baseCnt_ff + 32'h0000_0001;
			if (tickSec) begin
				minCnt_ff  <= tickMin ? 12'h000 : minCnt_ff + 12'h001;
				hourCnt_ff <= tickHour ? 12'h000 : hourCnt_ff + 12'h001;
			end
		end
	end

	// A scan-held trigger that is low keeps the count cleared, so timing restarts on each rise.
	trb_delay_timer uOnTimer (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.tickSec  (tickSec),
		.tickMin  (tickMin),
		.tickHour (tickHour),
		.unitSel  (onUnit),
		.delayVal (onDelay),
		.run      (onTrg_ff), // see R1
		.clear    (!onTrg_ff), // see R2
		.done     (onDone)
	);

	trb_delay_timer uOffTimer (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.tickSec  (tickSec),
		.tickMin  (tickMin),
		.tickHour (tickHour),
		.unitSel  (offUnit),
		.delayVal (offDelay),
		.run      (offRun_ff),
		.clear    (offClear),
		.done     (offDone)
	);

	// Off-delay decisions in priority order: reset, trigger high, fall, expiry.
	always @* begin
		nxt_offOut = offOut_ff;
		nxt_offRun = offRun_ff;
		offClear   = 1'b0;
		if (scanTick) begin
			if (inEff[`TRB_IN_OFF_RST]) begin
				nxt_offOut = 1'b0; // see R8
				nxt_offRun = 1'b0;
				offClear   = 1'b1;
			end else if (inEff[`TRB_IN_OFF_TRG]) begin
				nxt_offOut = 1'b1; // see R5
				nxt_offRun = 1'b0;
				offClear   = 1'b1;
			end else if (offTrgPrev_ff) begin
				nxt_offOut = 1'b1; // see R6
				nxt_offRun = 1'b1;
				offClear   = 1'b1; // see R7
			end else if (offRun_ff && offDone) begin
				nxt_offOut = 1'b0; // see R6
				nxt_offRun = 1'b0;
				offClear   = 1'b1;
			end
		end
	end

	// Every block updates only on scanTick, comparing against the previous scan's sample.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			onOut_ff      <= 1'b0;
			onTrg_ff      <= 1'b0;
			offOut_ff     <= 1'b0;
			offRun_ff     <= 1'b0;
			offTrgPrev_ff <= 1'b0;
			tglOut_ff     <= 1'b0; // see R12
			tglPrev_ff    <= `TRB_TGL_PREV_RESET; // see R13
			latOut_ff     <= 1'b0;
		end else if (clkEn) begin
			offOut_ff <= nxt_offOut;
			offRun_ff <= nxt_offRun;
			if (scanTick) begin
				onTrg_ff      <= inEff[`TRB_IN_ON_TRG]; // see R16
				onOut_ff      <= inEff[`TRB_IN_ON_TRG] && onTrg_ff && onDone; // see R1
				offTrgPrev_ff <= inEff[`TRB_IN_OFF_TRG]; // see R16
				tglPrev_ff    <= inEff[`TRB_IN_TGL_TRG]; // see R16
				if (inEff[`TRB_IN_TGL_RST]) begin
					tglOut_ff <= 1'b0; // see R11
				end else if (inEff[`TRB_IN_TGL_TRG] && !tglPrev_ff) begin
					tglOut_ff <= !tglOut_ff; // see R10
				end
				if (inEff[`TRB_IN_LAT_RST]) begin
					latOut_ff <= 1'b0; // see R14
				end else if (inEff[`TRB_IN_LAT_SET]) begin
					latOut_ff <= 1'b1; // see R14
				end
			end
		end
	end

	// The panel copy reloads every enabled cycle, with zero in place of the delay while unlinked.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			onLink_ff      <= 1'b0;
			offLink_ff     <= 1'b0;
			onPanDelay_ff  <= {`TRB_DELAY_W{1'b0}};
			offPanDelay_ff <= {`TRB_DELAY_W{1'b0}};
			onPanUnit_ff   <= `TRB_UNIT_SEC;
			offPanUnit_ff  <= `TRB_UNIT_SEC;
		end else if (clkEn) begin
			onLink_ff      <= onParamLink;
			offLink_ff     <= offParamLink;
			onPanDelay_ff  <= onParamLink ? onDelay : {`TRB_DELAY_W{1'b0}}; // see R15
			offPanDelay_ff <= offParamLink ? offDelay : {`TRB_DELAY_W{1'b0}}; // see R15
			onPanUnit_ff   <= onParamLink ? onUnit : `TRB_UNIT_SEC;
			offPanUnit_ff  <= offParamLink ? offUnit : `TRB_UNIT_SEC;
		end
	end

	assign onDelayOut    = onOut_ff; // see R3
	assign offDelayOut   = offOut_ff;
	assign toggleOut     = tglOut_ff;
	assign latchOut      = latOut_ff;
	assign onPanelValid  = onLink_ff;
	assign onPanelDelay  = onPanDelay_ff;
	assign onPanelUnit   = onPanUnit_ff;
	assign offPanelValid = offLink_ff;
	assign offPanelDelay = offPanDelay_ff;
	assign offPanelUnit  = offPanUnit_ff;

endmodule // trb_function_blocks

// File: tb/trb_term_model.sv
/* Input terminal model for the function blocks.
   Assumes the bench changes its request just after a rising core_clk edge. */
`timescale 1ns/1ns
module trb_term_model (
	input  wire [6:0] want,
	output reg  [6:0] blockIn
);
	// Terminals are unrelated to the core clock, so a level lands mid-cycle.
	initial blockIn = 7'h00;
	always @(want) blockIn <= #3 want;
endmodule // trb_term_model

// File: tb/trb_fb_props.sv
/* Checker for the timer and relay blocks.
   Assumes it is bound to trb_function_blocks and sees only its ports. */
`timescale 1ns/1ns
`include "trb_consts.vh"
module trb_fb_props (
	input wire                    core_clk,
	input wire                    resetn,
	input wire                    clkEn,
	input wire                    scanTick,
	input wire [`TRB_IN_W-1:0]    blockIn,
	input wire [`TRB_IN_W-1:0]    blockInConn,
	input wire [`TRB_DELAY_W-1:0] onDelayVal,
	input wire                    onParamLink,
	input wire                    onDelayOut,
	input wire                    offDelayOut,
	input wire                    toggleOut,
	input wire                    latchOut,
	input wire                    onPanelValid,
	input wire [`TRB_DELAY_W-1:0] onPanelDelay
);
	// Shadow synchroniser, so the properties see what a scan samples.
	reg  [6:0] syncA_ff;
	reg  [6:0] syncB_ff;
	reg        tglPrev_ff;
	wire       scan = clkEn & scanTick;
	wire [6:0] eff  = syncB_ff & blockInConn;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_ff   <= 7'h00;
			syncB_ff   <= 7'h00;
			tglPrev_ff <= 1'b1;
		end else if (clkEn) begin
			syncA_ff <= blockIn;
			syncB_ff <= syncA_ff;
			if (scanTick) tglPrev_ff <= eff[3];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_latch_set: assert property (scan && eff[5] && !eff[6] |=> latchOut)
		else $error("latch did not set");
	a_latch_clear: assert property (scan && eff[6] |=> !latchOut)
		else $error("latch did not clear");
	a_scan_hold: assert property (!scan |=> $stable({onDelayOut, offDelayOut, toggleOut, latchOut}))
		else $error("output moved between scans");
	a_off_reset: assert property (scan && eff[2] |=> !offDelayOut)
		else $error("off-delay reset ignored");
	a_off_trig: assert property (scan && eff[1] && !eff[2] |=> offDelayOut)
		else $error("off-delay not high");
	a_on_low: assert property (scan && !eff[0] |=> !onDelayOut)
		else $error("on-delay high with trigger low");
	a_on_rise: assert property ($rose(onDelayOut) |-> $past(scan) && $past(eff[0]))
		else $error("on-delay rose without trigger");
	a_tgl_reset: assert property (scan && eff[4] |=> !toggleOut)
		else $error("toggle reset ignored");
	a_tgl_edge: assert property (scan && eff[3] && !tglPrev_ff && !eff[4] |=> toggleOut != $past(toggleOut))
		else $error("toggle missed an edge");
	a_panel_clamp: assert property (clkEn && onParamLink && onDelayVal > 14'h270F
		|=> onPanelValid && onPanelDelay == 14'h270F)
		else $error("panel delay not clamped");
	cover property (scan && eff[5]);
	cover property ($fell(offDelayOut));
	cover property ($rose(onDelayOut));
endmodule // trb_fb_props
bind trb_function_blocks trb_fb_props u_props (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
	.scanTick(scanTick), .blockIn(blockIn), .blockInConn(blockInConn), .onDelayVal(onDelayVal),
	.onParamLink(onParamLink), .onDelayOut(onDelayOut), .offDelayOut(offDelayOut), .toggleOut(toggleOut),
	.latchOut(latchOut), .onPanelValid(onPanelValid), .onPanelDelay(onPanelDelay));

// File: tb/tb_timer_relay_function_blocks.sv
/* Self-checking bench for the timer and relay blocks.
   Assumes a short time base (TICK_CYCLES 4) and terminal inputs from trb_term_model. */
`timescale 1ns/1ns
`include "trb_consts.vh"
module tb_timer_relay_function_blocks;
	reg         core_clk = 0;
	reg         resetn = 0;
	reg         clkEn = 1;
	reg         scanTick = 0;
	reg  [6:0]  want = 7'h00;
	reg  [6:0]  blockInConn = 7'h7F;
	reg  [13:0] onDelayVal = 14'h0002;
	reg  [13:0] offDelayVal = 14'h0003;
	reg         onParamLink = 0;
	reg         offParamLink = 0;
	reg  [1:0]  onDelayUnit = 2'h0;
	reg  [1:0]  offDelayUnit = 2'h0;
	wire [6:0]  blockIn;
	wire        onDelayOut, offDelayOut, toggleOut, latchOut;
	wire        onPanelValid, offPanelValid;
	wire [13:0] onPanelDelay, offPanelDelay;
	wire [1:0]  onPanelUnit, offPanelUnit;
	reg  [16:0] r = 17'h1_83B0;
	reg         expLatch, expTgl, prevTg;
	integer     fails = 0, checks = 0, i, n;
	always #5 core_clk = ~core_clk;
	trb_term_model u_term (.want(want), .blockIn(blockIn));
	trb_function_blocks #(.TICK_CYCLES(4)) uut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.scanTick(scanTick), .blockIn(blockIn), .blockInConn(blockInConn), .onDelayVal(onDelayVal),
		.onDelayUnit(onDelayUnit), .offDelayVal(offDelayVal), .offDelayUnit(offDelayUnit),
		.onParamLink(onParamLink), .offParamLink(offParamLink), .onDelayOut(onDelayOut),
		.offDelayOut(offDelayOut), .toggleOut(toggleOut), .latchOut(latchOut),
		.onPanelValid(onPanelValid), .onPanelDelay(onPanelDelay), .onPanelUnit(onPanelUnit),
		.offPanelValid(offPanelValid), .offPanelDelay(offPanelDelay), .offPanelUnit(offPanelUnit));
	function [16:0] lfsr(input [16:0] s);
		lfsr = {s[15:0], s[16] ^ s[13]};
	endfunction
	// An unlinked panel reads zero; a linked one reads the delay clamped into its legal range.
	function [13:0] panDelay(input link, input [13:0] v);
		panDelay = !link ? 14'h0000 : (v < `TRB_DELAY_MIN) ? `TRB_DELAY_MIN :
			(v > `TRB_DELAY_MAX) ? `TRB_DELAY_MAX : v;
	endfunction
	function [1:0] panUnit(input link, input [1:0] u);
		panUnit = (link && (u == `TRB_UNIT_MIN || u == `TRB_UNIT_HOUR)) ? u : `TRB_UNIT_SEC;
	endfunction
	task check(input seen, input exp, input [63:0] msg);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t: %0s", $time, msg);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks=%0d fails=%0d", checks, fails);
			if (fails == 0 && checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	task doReset;
		begin
			@(posedge core_clk);
			resetn <= 0;
			repeat (6) @(posedge core_clk);
			resetn <= 1;
			expLatch = 0;
			expTgl = 0;
			prevTg = 1;
			#1 check(toggleOut, 0, "tglpwr");
		end
	endtask
	// Inputs are settled through both sync stages before the scan pulse.
	task doScan(input [6:0] w, input [6:0] c);
		reg [6:0] e;
		begin
			e = w & c;
			@(posedge core_clk);
			want <= w;
			blockInConn <= c;
			repeat (3) @(posedge core_clk);
			scanTick <= 1;
			@(posedge core_clk);
			scanTick <= 0;
			#1;
			expLatch = e[6] ? 1'b0 : (e[5] ? 1'b1 : expLatch);
			expTgl = e[4] ? 1'b0 : ((e[3] && !prevTg) ? ~expTgl : expTgl);
			prevTg = e[3];
			check(latchOut, expLatch, "latch");
			check(toggleOut, expTgl, "toggle");
			if (e[2]) check(offDelayOut, 0, "offrst");
			else if (e[1]) check(offDelayOut, 1, "offtrg");
			if (!e[0]) check(onDelayOut, 0, "onlow");
		end
	endtask
	// Starts from a low trigger so the count is known to be clear at the first high scan.
	task onTime(input [13:0] d, input [1:0] u);
		begin
			@(posedge core_clk);
			onDelayVal <= d;
			onDelayUnit <= u;
			doScan(7'h00, 7'h7F);
			doScan(7'h01, 7'h7F);
			n = 0;
			while (onDelayOut !== 1'b1 && n < 100) begin
				doScan(7'h01, 7'h7F);
				n = n + 1;
			end
		end
	endtask
	initial begin
		#500000;
		fails = fails + 1;
		finish_test;
	end
	initial begin
		doReset;
		doScan(7'h60, 7'h7F);
		for (i = 0; i < 60; i = i + 1) begin
			r = lfsr(r);
			@(posedge core_clk);
			onParamLink <= r[0];
			offParamLink <= r[1];
			onDelayVal <= (i == 1) ? 14'h0000 : r[16:3];
			onDelayUnit <= r[4:3];
			offDelayVal <= (i == 2) ? `TRB_DELAY_MAX : {r[2:0], r[16:6]};
			offDelayUnit <= r[8:7];
			doScan(r[6:0], r[13:7] | r[16:10]);
			check(onPanelValid, onParamLink, "pvalid");
			check(onPanelDelay == panDelay(onParamLink, onDelayVal), 1, "pdelay");
			check(onPanelUnit == panUnit(onParamLink, onDelayUnit), 1, "punit");
			check(offPanelValid, offParamLink, "pvalid");
			check(offPanelDelay == panDelay(offParamLink, offDelayVal), 1, "pdelay");
			check(offPanelUnit == panUnit(offParamLink, offDelayUnit), 1, "punit");
		end
		// Freeze: a scan with the enable low must change nothing.
		@(posedge core_clk);
		clkEn <= 0;
		scanTick <= 1;
		want <= ~want;
		repeat (4) @(posedge core_clk);
		clkEn <= 1;
		scanTick <= 0;
		#1 check(latchOut, expLatch, "freeze");
		check(toggleOut, expTgl, "freeze");
		// Scans are five cycles apart and a seconds hundredth is four, so two hundredths need two scans.
		onTime(14'h0002, `TRB_UNIT_SEC);
		check(onDelayOut, 1, "ondly");
		check(n == 2, 1, "ondlyn");
		doScan(7'h00, 7'h7F);
		doScan(7'h01, 7'h7F);
		doScan(7'h01, 7'h7F);
		check(onDelayOut, 0, "onclr");
		// A minute hundredth is sixty seconds ticks; its phase is free, hence the span of scans.
		onTime(14'h0002, `TRB_UNIT_MIN);
		check(n >= 49 && n <= 97, 1, "onmin");
		@(posedge core_clk);
		offDelayVal <= 14'h0003;
		offDelayUnit <= `TRB_UNIT_SEC;
		doScan(7'h02, 7'h7F);
		doScan(7'h00, 7'h7F);
		check(offDelayOut, 1, "offhold");
		n = 0;
		while (offDelayOut !== 1'b0 && n < 10) begin
			doScan(7'h00, 7'h7F);
			n = n + 1;
		end
		check(n >= 2 && n <= 3, 1, "offexp");
		@(posedge core_clk);
		want <= 7'h08;
		doReset;
		doScan(7'h08, 7'h7F);
		finish_test;
	end
endmodule // tb_timer_relay_function_blocks
